// [hw/pog_port_regs.sv]
// Functional notes
// - legacy mode: port G alternate functions only
// - async timer: G4 becomes oscillator input
// - async timer: G3 becomes oscillator output
// - G4/G3 analog paths reach timer oscillator
// - G2 carries address latch enable strobe
// - G1 carries read strobe
// - G0 carries write strobe
// - legacy mode: port C resets push-pull zero
// - reset acts without the clock
module pog_port_regs
    import pog_pkg::*;
#(
    parameter bit LEGACY_MODE = 1'b0
)
(
    input  wire logic                               clock,
    input  wire logic                               reset,
    input  wire logic [ADDR_W-1:0]                  address,
    input  wire logic                               read,
    input  wire logic                               write,
    input  wire logic [DATA_W-1:0]                  writedata,
    input  wire logic [3:0]                         byteenable,
    output logic      [DATA_W-1:0]                  readdata,
    output logic                                    waitrequest,
    input  wire logic [NUM_BANKS-1:0][BANK_W-1:0]   bankPinIn,
    output logic      [NUM_BANKS-1:0][BANK_W-1:0]   bankPinOut,
    output logic      [NUM_BANKS-1:0][BANK_W-1:0]   bankPinOe,
    output logic      [NUM_BANKS-1:0][BANK_W-1:0]   bankPullUp,
    input  wire logic [G_W-1:0]                     gPinIn,
    output logic      [G_W-1:0]                     gPinOut,
    output logic      [G_W-1:0]                     gPinOe,
    output logic      [G_W-1:0]                     gPullUp,
    output logic      [G_W-1:0]                     gInputEn,
    input  wire logic                               aleStrobe,
    input  wire logic                               rdStrobe,
    input  wire logic                               wrStrobe,
    output logic                                    analogPathEn,
    output logic                                    xtalAmpIn
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    localparam logic [BANK_W-1:0] RST_DIR_C = LEGACY_MODE ? RST_DIR_LEGACY : RST_DIR;

    logic [NUM_BANKS-1:0][BANK_W-1:0] outLatch_reg;
    logic [NUM_BANKS-1:0][BANK_W-1:0] outLatch_next;
    logic [NUM_BANKS-1:0][BANK_W-1:0] dir_reg;
    logic [NUM_BANKS-1:0][BANK_W-1:0] dir_next;
    logic [CTRL_W-1:0]                ctrl_reg;
    logic [CTRL_W-1:0]                ctrl_next;
    logic                             waitReq_reg;
    logic                             waitReq_next;
    logic [DATA_W-1:0]                readData_reg;
    logic [DATA_W-1:0]                readData_next;

    logic timer0_async_select;
    logic ext_mem_enable;

    assign timer0_async_select = ctrl_reg[CTRL_ASYNC_BIT];
    assign ext_mem_enable      = ctrl_reg[CTRL_EXTMEM_BIT];

    // ------------------------------------------------------------
    // avalon slave: one wait cycle, then answer
    // ------------------------------------------------------------
    always_comb
    begin
        logic                  accept;
        logic [ADDR_W-1:0]     base;
        outLatch_next = outLatch_reg;
        dir_next      = dir_reg;
        ctrl_next     = ctrl_reg;
        readData_next = readData_reg;
        waitReq_next  = 1'b1;
        accept        = 1'b0;
        base          = '0;
        // first edge of a request drops waitrequest for one cycle
        if ((read || write) && waitReq_reg)
        begin
            waitReq_next  = 1'b0;
            // unmapped addresses answer zero
            readData_next = '0;
            for (int b = 0; b < NUM_BANKS; b++)
            begin
                base = ADDR_W'(b * OFF_BANK_STRIDE);
                if (address == ADDR_W'(base + OFF_OUT_LATCH))
                begin
                    readData_next[BANK_W-1:0] = outLatch_reg[b];
                end
                if (address == ADDR_W'(base + OFF_DIR))
                begin
                    readData_next[BANK_W-1:0] = dir_reg[b];
                end
                if (address == ADDR_W'(base + OFF_IN_SAMPLE))
                begin
                    readData_next[BANK_W-1:0] = bankPinIn[b];
                end
            end
            if (address == OFF_CTRL)
            begin
                readData_next[CTRL_W-1:0] = ctrl_reg;
            end
        end
        // write lands on the edge where waitrequest is seen low
        accept = write && !waitReq_reg && byteenable[0];
        if (accept)
        begin
            for (int b = 0; b < NUM_BANKS; b++)
            begin
                base = ADDR_W'(b * OFF_BANK_STRIDE);
                if (address == ADDR_W'(base + OFF_OUT_LATCH))
                begin
                    outLatch_next[b] = writedata[BANK_W-1:0];
                end
                if (address == ADDR_W'(base + OFF_DIR))
                begin
                    dir_next[b] = writedata[BANK_W-1:0];
                end
            end
            if (address == OFF_CTRL)
            begin
                ctrl_next = writedata[CTRL_W-1:0];
            end
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            for (int b = 0; b < NUM_BANKS; b++)
            begin
                outLatch_reg[b] <= RST_LATCH;
                // legacy port C wakes as push-pull zero outputs
                dir_reg[b]      <= (b == BANK_C) ? RST_DIR_C : RST_DIR;
            end
            ctrl_reg     <= RST_CTRL;
            waitReq_reg  <= 1'b1;
            readData_reg <= '0;
        end
        else
        begin
            outLatch_reg <= outLatch_next;
            dir_reg      <= dir_next;
            ctrl_reg     <= ctrl_next;
            waitReq_reg  <= waitReq_next;
            readData_reg <= readData_next;
        end
    end

    assign readdata    = readData_reg;
    assign waitrequest = waitReq_reg;

    // ------------------------------------------------------------
    // pin drive for ports A to E
    // ------------------------------------------------------------
    logic [NUM_BANKS-1:0][BANK_W-1:0] pinOut_reg;
    logic [NUM_BANKS-1:0][BANK_W-1:0] pinOut_next;
    logic [NUM_BANKS-1:0][BANK_W-1:0] pinOe_reg;
    logic [NUM_BANKS-1:0][BANK_W-1:0] pinOe_next;
    logic [NUM_BANKS-1:0][BANK_W-1:0] pullUp_reg;
    logic [NUM_BANKS-1:0][BANK_W-1:0] pullUp_next;

    always_comb
    begin
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            pinOut_next[b] = outLatch_next[b];
            pinOe_next[b]  = dir_next[b];
            // latch high on an input pin turns the pull-up on
            pullUp_next[b] = outLatch_next[b] & ~dir_next[b];
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            for (int b = 0; b < NUM_BANKS; b++)
            begin
                // pins take their reset level with no clock running
                pinOut_reg[b] <= RST_LATCH;
                pinOe_reg[b]  <= (b == BANK_C) ? RST_DIR_C : RST_DIR;
                pullUp_reg[b] <= RST_LATCH;
            end
        end
        else
        begin
            pinOut_reg <= pinOut_next;
            pinOe_reg  <= pinOe_next;
            pullUp_reg <= pullUp_next;
        end
    end

    assign bankPinOut = pinOut_reg;
    assign bankPinOe  = pinOe_reg;
    assign bankPullUp = pullUp_reg;

    // ------------------------------------------------------------
    // port G override network
    // ------------------------------------------------------------
    logic [G_W-1:0] pullup_override_en;
    logic [G_W-1:0] pullup_override_val;
    logic [G_W-1:0] dir_override_en;
    logic [G_W-1:0] dir_override_val;
    logic [G_W-1:0] value_override_en;
    logic [G_W-1:0] value_override_val;
    logic [G_W-1:0] input_en_override_en;
    logic [G_W-1:0] input_en_override_val;
    logic [G_W-1:0] gOut_reg;
    logic [G_W-1:0] gOut_next;
    logic [G_W-1:0] gOe_reg;
    logic [G_W-1:0] gOe_next;
    logic [G_W-1:0] gPull_reg;
    logic [G_W-1:0] gPull_next;
    logic [G_W-1:0] gInEn_reg;
    logic [G_W-1:0] gInEn_next;
    logic           analog_path_reg;
    logic           analog_path_next;
    logic           xtalIn_reg;
    logic           xtalIn_next;

    always_comb
    begin
        logic asyncNext;
        logic extNext;
        asyncNext = ctrl_next[CTRL_ASYNC_BIT];
        extNext   = ctrl_next[CTRL_EXTMEM_BIT];
        // oscillator pins leave the port entirely
        pullup_override_en    = '0;
        pullup_override_val   = '0;
        dir_override_en       = '0;
        dir_override_val      = '0;
        value_override_en     = '0;
        value_override_val    = '0;
        input_en_override_en  = '0;
        input_en_override_val = '0;
        pullup_override_en[G_XTAL_IN_BIT]    = asyncNext;
        dir_override_en[G_XTAL_IN_BIT]       = asyncNext;
        input_en_override_en[G_XTAL_IN_BIT]  = asyncNext;
        pullup_override_en[G_XTAL_OUT_BIT]   = asyncNext;
        dir_override_en[G_XTAL_OUT_BIT]      = asyncNext;
        input_en_override_en[G_XTAL_OUT_BIT] = asyncNext;
        // memory strobes own G2..G0
        for (int i = G_WR_BIT; i <= G_ALE_BIT; i++)
        begin
            pullup_override_en[i] = extNext;
            dir_override_en[i]    = extNext;
            dir_override_val[i]   = 1'b1;
            value_override_en[i]  = extNext;
        end
        // strobe levels reach the pins one clock later
        value_override_val[G_ALE_BIT] = aleStrobe;
        value_override_val[G_RD_BIT]  = rdStrobe;
        value_override_val[G_WR_BIT]  = wrStrobe;
        // no general-purpose port G latch: idle pins stay undriven inputs
        for (int i = 0; i < G_W; i++)
        begin
            gPull_next[i] = pullup_override_en[i] ? pullup_override_val[i] : 1'b0;
            gOe_next[i]   = dir_override_en[i] ? dir_override_val[i] : 1'b0;
            gOut_next[i]  = value_override_en[i] ? value_override_val[i] : 1'b0;
            gInEn_next[i] = input_en_override_en[i] ? input_en_override_val[i] : 1'b1;
        end
        // oscillator pins hand their analog paths to the timer
        analog_path_next = asyncNext;
        xtalIn_next      = asyncNext & gPinIn[G_XTAL_IN_BIT];
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            gOut_reg        <= '0;
            gOe_reg         <= '0;
            gPull_reg       <= '0;
            gInEn_reg       <= '1;
            analog_path_reg <= 1'b0;
            xtalIn_reg      <= 1'b0;
        end
        else
        begin
            gOut_reg        <= gOut_next;
            gOe_reg         <= gOe_next;
            gPull_reg       <= gPull_next;
            gInEn_reg       <= gInEn_next;
            analog_path_reg <= analog_path_next;
            xtalIn_reg      <= xtalIn_next;
        end
    end

    assign gPinOut      = gOut_reg;
    assign gPinOe       = gOe_reg;
    assign gPullUp      = gPull_reg;
    assign gInputEn     = gInEn_reg;
    assign analogPathEn = analog_path_reg;
    assign xtalAmpIn    = xtalIn_reg;

endmodule

// [hw/pog_pkg.sv]
package pog_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W    = 6;
    localparam int DATA_W    = 32;
    localparam int BANK_W    = 8;
    localparam int NUM_BANKS = 5;
    localparam int G_W       = 5;
    localparam int CTRL_W    = 2;

    // ------------------------------------------------------------
    // byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_BANK_STRIDE = 6'h0C;
    localparam logic [ADDR_W-1:0] OFF_OUT_LATCH   = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_DIR         = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_IN_SAMPLE   = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_CTRL        = 6'h3C;

    // bank index of port C
    localparam int BANK_C = 2;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_ASYNC_BIT  = 0;
    localparam int CTRL_EXTMEM_BIT = 1;

    // ------------------------------------------------------------
    // port G pin positions
    // ------------------------------------------------------------
    localparam int G_XTAL_IN_BIT  = 4;
    localparam int G_XTAL_OUT_BIT = 3;
    localparam int G_ALE_BIT      = 2;
    localparam int G_RD_BIT       = 1;
    localparam int G_WR_BIT       = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [BANK_W-1:0] RST_LATCH      = 8'h00;
    localparam logic [BANK_W-1:0] RST_DIR        = 8'h00;
    localparam logic [BANK_W-1:0] RST_DIR_LEGACY = 8'hFF;
    localparam logic [CTRL_W-1:0] RST_CTRL       = 2'h0;

endpackage

// [verification/pog_port_regs_checker.sv]
module pog_port_regs_checker
    import pog_pkg::*;
(
    input wire logic           clock,
    input wire logic           reset,
    input wire logic           read,
    input wire logic           write,
    input wire logic           waitrequest,
    input wire logic [G_W-1:0] gPinIn,
    input wire logic [G_W-1:0] gPinOut,
    input wire logic [G_W-1:0] gPinOe,
    input wire logic [G_W-1:0] gPullUp,
    input wire logic [G_W-1:0] gInputEn,
    input wire logic           aleStrobe,
    input wire logic           rdStrobe,
    input wire logic           wrStrobe,
    input wire logic           analogPathEn,
    input wire logic           xtalAmpIn
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // bus handshake and port G overrides
    // ------------------------------------------------------------
    sequence reqSeen;
        (read || write) && waitrequest;
    endsequence
    sequence answerPulse;
        !waitrequest ##1 waitrequest;
    endsequence
    req_answer_a: assert property (reqSeen |=> answerPulse)
        else $error("request not answered by a one cycle pulse");
    ale_strobe_a: assert property (gPinOe[2] && $past(gPinOe[2]) |-> gPinOut[2] == $past(aleStrobe))
        else $error("G2 does not carry the latch enable strobe");
    rd_strobe_a: assert property (gPinOe[1] && $past(gPinOe[1]) |-> gPinOut[1] == $past(rdStrobe))
        else $error("G1 does not carry the read strobe");
    wr_strobe_a: assert property (gPinOe[0] && $past(gPinOe[0]) |-> gPinOut[0] == $past(wrStrobe))
        else $error("G0 does not carry the write strobe");
    extmem_group_a: assert property ((gPinOe[2:0] == 3'h0 || gPinOe[2:0] == 3'h7) && gPullUp == 5'h00)
        else $error("strobe pins not overridden as a group");
    extmem_idle_a: assert property (gPinOe[2:0] == 3'h0 |-> gPinOut[2:0] == 3'h0)
        else $error("strobe pins drive while memory interface off");
    xtal_path_a: assert property (analogPathEn && $past(analogPathEn) |-> xtalAmpIn == $past(gPinIn[4]))
        else $error("crystal input does not follow G4");
    xtal_quiet_a: assert property (!analogPathEn && !$past(analogPathEn) |-> !xtalAmpIn)
        else $error("crystal input active while timer clock is synchronous");
    xtal_detach_a: assert property (gInputEn[4:3] == (analogPathEn ? 2'b00 : 2'b11))
        else $error("G4 G3 digital input not detached for the crystal");
    legacy_g_a: assert property (gPinOe[4:3] == 2'b00 && gPinOut[4:3] == 2'b00)
        else $error("G4 G3 driven as general purpose pins");
endmodule

bind pog_port_regs pog_port_regs_checker chk (.clock, .reset, .read, .write, .waitrequest, .gPinIn, .gPinOut,
    .gPinOe, .gPullUp, .gInputEn, .aleStrobe, .rdStrobe, .wrStrobe, .analogPathEn, .xtalAmpIn);

// [verification/pog_far_side.sv]
module pog_far_side
    import pog_pkg::*;
(
    input wire logic           clock,
    input wire logic           reset,
    input wire logic [G_W-1:0] gPinOut,
    input wire logic [G_W-1:0] gPinOe,
    output logic     [G_W-1:0] gPinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // crystal and memory side of port G
    // ------------------------------------------------------------
    // driven pins read back their level, released pins flip every
    // cycle; the crystal on G4 oscillates the same way
    always @(posedge clock or posedge reset)
    begin
        if (reset)
            gPinIn <= '0;
        else
            for (int i = 0; i < G_W; i++)
                gPinIn[i] <= gPinOe[i] ? gPinOut[i] : ~gPinIn[i];
    end
endmodule

// [verification/port_override_and_port_regs_bench.sv]
module port_override_and_port_regs_bench
    import pog_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                               clock = 0, reset = 1, clkRun = 1, read = 0, write = 0;
    logic [ADDR_W-1:0]                  address = '0;
    logic [DATA_W-1:0]                  writedata = '0, readdata, rdata, v;
    logic [3:0]                         byteenable = '0;
    logic [NUM_BANKS-1:0][BANK_W-1:0]   bankPinIn = '0, bankPinOut, bankPinOe, bankPullUp, bankOeStd;
    logic [G_W-1:0]                     gPinIn, gPinOut, gPinOe, gPullUp, gInputEn;
    logic                               aleStrobe = 0, rdStrobe = 0, wrStrobe = 0, g4;
    logic                               waitrequest, analogPathEn, xtalAmpIn;
    logic [31:0]                        seed = 32'h17d2_9c2e;
    logic [7:0]                         lat [NUM_BANKS], dir [NUM_BANKS];
    logic [ADDR_W-1:0]                  offs [3] = '{OFF_OUT_LATCH, OFF_DIR, OFF_IN_SAMPLE};
    int                                 n_fail = 0, n_compared = 0, b, k;

    always #25 clock = clkRun & ~clock;

    pog_port_regs #(.LEGACY_MODE(1'b1)) DUT (.clock, .reset, .address, .read, .write, .writedata, .byteenable,
        .readdata, .waitrequest, .bankPinIn, .bankPinOut, .bankPinOe, .bankPullUp, .gPinIn, .gPinOut, .gPinOe,
        .gPullUp, .gInputEn, .aleStrobe, .rdStrobe, .wrStrobe, .analogPathEn, .xtalAmpIn);
    pog_far_side far (.clock, .reset, .gPinOut, .gPinOe, .gPinIn);
    // second copy outside legacy mode: port C must wake as inputs
    pog_port_regs #(.LEGACY_MODE(1'b0)) dutStd (.clock, .reset, .address, .read, .write, .writedata, .byteenable,
        .readdata(), .waitrequest(), .bankPinIn, .bankPinOut(), .bankPinOe(bankOeStd), .bankPullUp(), .gPinIn,
        .gPinOut(), .gPinOe(), .gPullUp(), .gInputEn(), .aleStrobe, .rdStrobe, .wrStrobe, .analogPathEn(),
        .xtalAmpIn());

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic report_and_stop();
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= d;
        byteenable <= be;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0)
        begin
            n_fail++;
            report_and_stop();
        end
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic cmpBank(input int bk);
        logic [ADDR_W-1:0] base;
        base = ADDR_W'(bk) * OFF_BANK_STRIDE;
        bus(0, base + OFF_OUT_LATCH, 0, 0);
        chk("latch", lat[bk], rdata);
        bus(0, base + OFF_DIR, 0, 0);
        chk("dir", dir[bk], rdata);
        chk("pinOut", lat[bk], bankPinOut[bk]);
        chk("pinOe", dir[bk], bankPinOe[bk]);
        chk("pullUp", lat[bk] & ~dir[bk], bankPullUp[bk]);
    endtask

    task automatic resetAll();
        for (int i = 0; i < NUM_BANKS; i++)
        begin
            lat[i] = 8'h00;
            dir[i] = (i == BANK_C) ? 8'hFF : 8'h00;
            cmpBank(i);
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        resetAll();
        repeat (40)
        begin
            b = xs() % NUM_BANKS;
            k = xs() % 3;
            if (b == BANK_C && k == 1)
                k = 0;
            v = xs();
            bus(1, ADDR_W'(b) * OFF_BANK_STRIDE + offs[k], v, {3'h0, v[8]});
            if (v[8] && k == 0)
                lat[b] = v[7:0];
            if (v[8] && k == 1)
                dir[b] = v[7:0];
            bankPinIn[b] <= v[31:24];
            cmpBank(b);
            bus(0, ADDR_W'(b) * OFF_BANK_STRIDE + OFF_IN_SAMPLE, 0, 0);
            chk("sample", v[31:24], rdata);
        end
        for (int c = 0; c < 4; c++)
        begin
            bus(1, OFF_CTRL, c, 4'h1);
            bus(0, OFF_CTRL, 0, 0);
            chk("ctrl", c, rdata);
            chk("gOe", c[1] ? 5'h07 : 5'h00, gPinOe);
            chk("gInEn", c[0] ? 5'h07 : 5'h1F, gInputEn);
            chk("analog", c[0], analogPathEn);
            chk("gPull", 0, gPullUp);
            repeat (8)
            begin
                v = xs();
                {aleStrobe, rdStrobe, wrStrobe} <= v[2:0];
                @(posedge clock);
                g4 = gPinIn[G_XTAL_IN_BIT];
                @(posedge clock);
                chk("gOut", c[1] ? v[2:0] : 3'h0, gPinOut);
                chk("xtalIn", c[0] & g4, xtalAmpIn);
            end
        end
        // reset with the clock stopped
        clkRun = 1'b0;
        #100;
        reset = 1'b1;
        #10;
        for (int i = 0; i < NUM_BANKS; i++)
        begin
            chk("rstOut", 0, bankPinOut[i]);
            chk("rstOe", i == BANK_C ? 8'hFF : 8'h00, bankPinOe[i]);
        end
        chk("rstG", 0, gPinOe);
        chk("rstOeStd", RST_DIR, bankOeStd[BANK_C]);
        clkRun = 1'b1;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        resetAll();
        report_and_stop();
    end
endmodule
